//--- hw/line_pickup_remote_open_logic.sv
// Line pickup, remote-open detector, reclose block and overload enable logic
`timescale 1ns/1ps
`include "lpro_cfg.svh"
module line_pickup_remote_open_logic #(
    parameter int TICK_CYCLES = `LPRO_TICK_CYCLES
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire lpro_pkg::meas_s       meas,
    input  wire lpro_pkg::trip_src_s   trip_src,
    input  wire logic                  trip_any,
    input  wire lpro_pkg::reclose_sel_s reclose_sel,
    input  wire logic                  switch_onto_fault_select,
    input  wire logic                  bypass_trip_delay,
    input  wire logic                  remote_open_select,
    input  wire lpro_pkg::ms_t         remote_open_delay_setting,
    input  wire logic                  overload_select,
    input  wire logic                  level1_pickup,
    input  wire logic                  level2_pickup,
    input  wire lpro_pkg::ms_t         level1_delay_setting,
    input  wire lpro_pkg::ms_t         level2_delay_setting,
    output logic                       reclose_initiate,
    output logic                       reclose_cancel,
    output logic                       line_pickup_enable,
    output logic                       line_pickup_trip,
    output logic                       remote_open_trip,
    output logic                       remote_open_blocked,
    output logic                       overload_level1,
    output logic                       overload_level2
);
    import lpro_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam ms_t DEAD_MS  = ms_t'(`LPRO_DEAD_LINE_MS);
    localparam ms_t ENERG_MS = ms_t'(`LPRO_ENERGIZE_MS);
    localparam ms_t TDLY_MS  = ms_t'(`LPRO_TRIP_DELAY_MS);

    // Millisecond tick shared by every timer
    logic [TW-1:0] tick_cnt_reg;
    logic [TW-1:0] tick_cnt_next;
    logic          tick;

    always_comb begin
        tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));
        tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    // Line pickup
    logic dead_line;
    logic energize_done;
    logic enable_run;
    logic lp_enable;
    logic lp_request;
    logic lp_delayed;
    logic enable_timer_done;

    always_comb begin
        // Open breaker detector: no load current and voltage dropped out
        dead_line  = switch_onto_fault_select & ~meas.load_current_detector
                     & ~meas.pos_seq_voltage_detector;
        // The energize timer output acts as a fast reset of the enable timer
        enable_run = dead_line & ~energize_done;
        lp_request = lp_enable & switch_onto_fault_select
                     & (meas.pos_seq_overcurrent_unit | meas.zone2_phase
                        | meas.zone2_ground);
    end

    // Enable holds once timed; the energize timer or a cleared switch_onto_fault_select takes it away
    logic lp_hold_reg;
    logic lp_hold_next;

    always_comb begin
        lp_hold_next = lp_hold_reg;
        if (!switch_onto_fault_select || energize_done) begin
            lp_hold_next = 1'b0;
        end else if (enable_timer_done) begin
            lp_hold_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lp_hold_reg <= 1'b0;
        end else begin
            lp_hold_reg <= lp_hold_next;
        end
    end

    assign lp_enable = lp_hold_reg;

    ms_timer #(.W(`LPRO_MS_WIDTH)) u_dead_line_enable_timer (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .tick     (tick),
        .run      (enable_run),
        .delay_ms (DEAD_MS),
        .expired  (enable_timer_done)
    );

    ms_timer #(.W(`LPRO_MS_WIDTH)) u_energize_reset_timer (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .tick     (tick),
        .run      (meas.pos_seq_voltage_detector & lp_hold_reg),
        .delay_ms (ENERG_MS),
        .expired  (energize_done)
    );

    ms_timer #(.W(`LPRO_MS_WIDTH)) u_pickup_trip_delay_timer (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .tick     (tick),
        .run      (lp_request),
        .delay_ms (TDLY_MS),
        .expired  (lp_delayed)
    );

    logic lp_trip_reg;
    logic lp_trip_next;

    always_comb begin
        // Bypass trades load security for speed on reclosed lines
        lp_trip_next = bypass_trip_delay ? lp_request : (lp_request & lp_delayed);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lp_trip_reg <= 1'b0;
        end else begin
            lp_trip_reg <= lp_trip_next;
        end
    end

    // Remote-open detector
    ro_state_e ro_state_reg;
    ro_state_e ro_state_next;
    logic      charging;
    logic      ro_path;
    logic      ro_delayed;

    always_comb begin
        charging = |meas.charging;
        ro_state_next = ro_state_reg;
        unique case (ro_state_reg)
            RO_IDLE: begin
                if (charging && !meas.fault_detector) begin
                    ro_state_next = RO_BLOCK;
                end else if (meas.fault_detector) begin
                    ro_state_next = RO_ARMED;
                end
            end
            RO_BLOCK: begin
                if (!charging) begin
                    ro_state_next = RO_IDLE;
                end
            end
            RO_ARMED: begin
                if (!meas.fault_detector) begin
                    ro_state_next = RO_IDLE;
                end
            end
            default: ro_state_next = RO_IDLE;
        endcase
        // A balanced fault leaves all phases uncharged, so no path forms
        ro_path = remote_open_select && (ro_state_reg == RO_ARMED)
                  && charging && meas.fault_detector;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ro_state_reg <= RO_IDLE;
        end else begin
            ro_state_reg <= ro_state_next;
        end
    end

    ms_timer #(.W(`LPRO_MS_WIDTH)) u_remote_open_delay_timer (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .tick     (tick),
        .run      (ro_path),
        .delay_ms (remote_open_delay_setting),
        .expired  (ro_delayed)
    );

    logic ro_trip_reg;
    logic ro_trip_next;

    always_comb begin
        ro_trip_next = ro_path & ro_delayed;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ro_trip_reg <= 1'b0;
        end else begin
            ro_trip_reg <= ro_trip_next;
        end
    end

    // Line overload
    logic ol1_done;
    logic ol2_done;

    ms_timer #(.W(`LPRO_MS_WIDTH)) u_overload_level1_timer (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .tick     (tick),
        .run      (overload_select & level1_pickup),
        .delay_ms (level1_delay_setting),
        .expired  (ol1_done)
    );

    ms_timer #(.W(`LPRO_MS_WIDTH)) u_overload_level2_timer (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .tick     (tick),
        .run      (overload_select & level2_pickup),
        .delay_ms (level2_delay_setting),
        .expired  (ol2_done)
    );

    // Reclose block
    logic rc_reg;
    logic rc_next;
    logic ri_reg;
    logic ri_next;
    logic blk;

    always_comb begin
        blk = (reclose_sel.zone3_delayed_reclose_block & trip_src.zone3_delayed)
            | (reclose_sel.zone4_delayed_reclose_block & trip_src.zone4_delayed)
            | (reclose_sel.zone1_phase_reclose_block & trip_src.zone1_phase)
            | (reclose_sel.any_zone2_phase_reclose_block & trip_src.any_zone2_phase)
            | (reclose_sel.configurable_trip_reclose_block & trip_src.configurable);
        rc_next = trip_any & blk;
        ri_next = trip_any & ~blk;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rc_reg <= 1'b0;
            ri_reg <= 1'b0;
        end else begin
            rc_reg <= rc_next;
            ri_reg <= ri_next;
        end
    end

    assign reclose_initiate    = ri_reg;
    assign reclose_cancel      = rc_reg;
    assign line_pickup_enable  = lp_hold_reg;
    assign line_pickup_trip    = lp_trip_reg;
    assign remote_open_trip    = ro_trip_reg;
    assign remote_open_blocked = (ro_state_reg == RO_BLOCK);
    assign overload_level1     = ol1_done;
    assign overload_level2     = ol2_done;

    chk_cancel_excl: assert property (@(posedge ref_clk) disable iff (rst)
        !(reclose_cancel && reclose_initiate)) else $error("cancel with initiate");
    chk_zone3_block: assert property (@(posedge ref_clk) disable iff (rst)
        trip_any && trip_src.zone3_delayed && reclose_sel.zone3_delayed_reclose_block
        |=> reclose_cancel) else $error("zone3 not blocked");
    chk_lp_select: assert property (@(posedge ref_clk) disable iff (rst)
        !switch_onto_fault_select |=> !line_pickup_trip) else $error("lp while off");
    chk_lp_bypass: assert property (@(posedge ref_clk) disable iff (rst)
        bypass_trip_delay && lp_request |=> line_pickup_trip) else $error("bypass slow");
    chk_lp_delay: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(lp_request) && !bypass_trip_delay |=> !line_pickup_trip [*3])
        else $error("lp trip early");
    chk_ro_block: assert property (@(posedge ref_clk) disable iff (rst)
        remote_open_blocked |=> !remote_open_trip) else $error("blocked ro trip");
    chk_ro_select: assert property (@(posedge ref_clk) disable iff (rst)
        !remote_open_select |=> !remote_open_trip) else $error("ro while off");
    chk_ol_off: assert property (@(posedge ref_clk) disable iff (rst)
        !overload_select |=> ##1 !(overload_level1 || overload_level2))
        else $error("overload while off");

    // Remaining reclose selections, each forcing cancel on its own trip type, then initiate, line pickup, remote-open and overload checks
    chk_zone4_block: assert property (@(posedge ref_clk) disable iff (rst)
        trip_any && trip_src.zone4_delayed && reclose_sel.zone4_delayed_reclose_block
        |=> reclose_cancel) else $error("zone4 not blocked");
    chk_zone1_block: assert property (@(posedge ref_clk) disable iff (rst)
        trip_any && trip_src.zone1_phase && reclose_sel.zone1_phase_reclose_block
        |=> reclose_cancel) else $error("zone1 not blocked");
    chk_zone2_block: assert property (@(posedge ref_clk) disable iff (rst)
        trip_any && trip_src.any_zone2_phase && reclose_sel.any_zone2_phase_reclose_block
        |=> reclose_cancel) else $error("zone2 phase not blocked");
    chk_conf_block: assert property (@(posedge ref_clk) disable iff (rst)
        trip_any && trip_src.configurable && reclose_sel.configurable_trip_reclose_block
        |=> reclose_cancel) else $error("configurable trip not blocked");
    chk_ri_free: assert property (@(posedge ref_clk) disable iff (rst)
        trip_any && !blk |=> reclose_initiate) else $error("initiate missing");
    chk_lp_enable_timed: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(line_pickup_enable) |-> $past(enable_timer_done)) else $error("enable untimed");
    chk_lp_energize_reset: assert property (@(posedge ref_clk) disable iff (rst)
        energize_done |=> !line_pickup_enable) else $error("enable not fast reset");
    chk_lp_enable_off: assert property (@(posedge ref_clk) disable iff (rst)
        !switch_onto_fault_select |=> !line_pickup_enable) else $error("enable while off");
    chk_ro_latch_set: assert property (@(posedge ref_clk) disable iff (rst)
        (ro_state_reg == RO_IDLE) && charging && !meas.fault_detector
        |=> remote_open_blocked) else $error("block latch not set");
    chk_ro_fault_gate: assert property (@(posedge ref_clk) disable iff (rst)
        (ro_state_reg == RO_IDLE) && meas.fault_detector |=> !remote_open_blocked)
        else $error("latch set during fault");
    chk_ro_trip_path: assert property (@(posedge ref_clk) disable iff (rst)
        remote_open_trip |-> $past(ro_path)) else $error("ro trip without path");
    chk_ro_delay_start: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(ro_path) |=> !remote_open_trip) else $error("ro trip undelayed");
    chk_ol1_drop: assert property (@(posedge ref_clk) disable iff (rst)
        !level1_pickup |=> !overload_level1) else $error("level1 without pickup");
    chk_ol2_drop: assert property (@(posedge ref_clk) disable iff (rst)
        !level2_pickup |=> !overload_level2) else $error("level2 without pickup");
endmodule : line_pickup_remote_open_logic

//--- hw/lpro_cfg.svh
// Timing constants for line pickup, remote-open and overload logic
`ifndef LPRO_CFG_SVH
`define LPRO_CFG_SVH
`define LPRO_CLK_HZ        100000000
`define LPRO_TICK_HZ       1000
`define LPRO_TICK_CYCLES   (`LPRO_CLK_HZ / `LPRO_TICK_HZ)
`define LPRO_DEAD_LINE_MS  150
`define LPRO_ENERGIZE_MS   25
`define LPRO_TRIP_DELAY_MS 45
`define LPRO_MS_WIDTH      16
`endif

//--- hw/lpro_pkg.sv
// Types shared by the line pickup and remote-open logic
package lpro_pkg;
    typedef logic [15:0] ms_t;

    typedef struct packed {
        logic zone3_delayed;
        logic zone4_delayed;
        logic zone1_phase;
        logic any_zone2_phase;
        logic configurable;
    } trip_src_s;

    typedef struct packed {
        logic zone3_delayed_reclose_block;
        logic zone4_delayed_reclose_block;
        logic zone1_phase_reclose_block;
        logic any_zone2_phase_reclose_block;
        logic configurable_trip_reclose_block;
    } reclose_sel_s;

    typedef struct packed {
        logic [2:0] charging;
        logic       fault_detector;
        logic       load_current_detector;
        logic       pos_seq_voltage_detector;
        logic       pos_seq_overcurrent_unit;
        logic       zone2_phase;
        logic       zone2_ground;
    } meas_s;

    typedef enum logic [2:0] {
        RO_IDLE  = 3'b001,
        RO_BLOCK = 3'b010,
        RO_ARMED = 3'b100
    } ro_state_e;
endpackage : lpro_pkg

//--- hw/ms_timer.sv
// Millisecond pickup timer that clears when its input drops
`timescale 1ns/1ps
module ms_timer #(
    parameter int W = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         tick,
    input  wire logic         run,
    input  wire logic [W-1:0] delay_ms,
    output logic              expired
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         exp_reg;
    logic         exp_next;

    always_comb begin
        cnt_next = cnt_reg;
        exp_next = exp_reg;
        if (!run) begin
            cnt_next = '0;
            exp_next = 1'b0;
        end else if (cnt_reg >= delay_ms) begin
            exp_next = 1'b1;
        end else if (tick) begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_reg <= '0;
            exp_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            exp_reg <= exp_next;
        end
    end

    assign expired = exp_reg;
endmodule : ms_timer

//--- test/meas_model.sv
// Measurement and fault detector front end feeding the supervision logic
`timescale 1ns/1ps
module meas_model (
    input  wire logic            ref_clk,
    input  wire lpro_pkg::meas_s req,
    output lpro_pkg::meas_s      meas
);
    import lpro_pkg::*;
    // Detector outputs settle one logic clock after the power system changes
    always_ff @(posedge ref_clk) begin
        meas <= req;
    end
endmodule : meas_model

//--- test/tb_line_pickup_remote_open_logic.sv
// Self-checking bench for the line pickup and remote-open logic
`timescale 1ns/1ps
module tb_line_pickup_remote_open_logic;
    import lpro_pkg::*;
    // Short tick keeps the 150 ms dead-line wait near 1500 cycles
    localparam int TC = 10;
    logic         ref_clk = 1'b0;
    logic         rst = 1'b1;
    meas_s        req;
    meas_s        meas;
    trip_src_s    trip_src;
    reclose_sel_s reclose_sel;
    logic         trip_any, switch_onto_fault_select, bypass_trip_delay;
    logic         remote_open_select, overload_select, level1_pickup, level2_pickup;
    ms_t          remote_open_delay_setting, level1_delay_setting, level2_delay_setting;
    logic         reclose_initiate, reclose_cancel, line_pickup_enable, line_pickup_trip;
    logic         remote_open_trip, remote_open_blocked, overload_level1, overload_level2;
    int           error_cnt = 0;
    int           checks_done = 0;

    always #5 ref_clk = ~ref_clk;

    meas_model model (.ref_clk, .req, .meas);

    line_pickup_remote_open_logic #(.TICK_CYCLES(TC)) dut (
        .ref_clk, .rst, .meas, .trip_src, .trip_any, .reclose_sel,
        .switch_onto_fault_select, .bypass_trip_delay, .remote_open_select,
        .remote_open_delay_setting, .overload_select, .level1_pickup, .level2_pickup,
        .level1_delay_setting, .level2_delay_setting, .reclose_initiate,
        .reclose_cancel, .line_pickup_enable, .line_pickup_trip, .remote_open_trip,
        .remote_open_blocked, .overload_level1, .overload_level2
    );

    function automatic logic out(input int k);
        case (k)
            0: return reclose_initiate;
            1: return reclose_cancel;
            2: return line_pickup_enable;
            3: return line_pickup_trip;
            4: return remote_open_trip;
            5: return remote_open_blocked;
            6: return overload_level1;
            default: return overload_level2;
        endcase
    endfunction : out

    task automatic step(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic fail(input string m);
        error_cnt++;
        $display("ERROR t=%0t %s", $time, m);
    endtask : fail

    task automatic summarize;
        $display("errors=%0d checks=%0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic chk_bit(input int k, input logic e);
        checks_done++;
        if (out(k) !== e) fail($sformatf("output %0d is %b, expected %b", k, out(k), e));
    endtask : chk_bit

    // Bounded wait for output k to reach v; lands outside [lo,hi] count as mismatch
    task automatic chk_win(input int k, input logic v, input int lo, input int hi);
        int c;
        c = 0;
        while (out(k) !== v && c <= hi) begin
            step(1);
            c++;
        end
        checks_done++;
        if (c < lo || c > hi) begin
            fail($sformatf("output %0d reached %b after %0d cycles", k, v, c));
            if (c > hi) summarize();
        end
    endtask : chk_win

    // Timer window: one tick of phase slack plus the detector and output stages
    task automatic chk_ms(input int k, input logic v, input int d);
        chk_win(k, v, d * TC - TC - 2, d * TC + TC + 6);
    endtask : chk_ms

    task automatic hold(input int k, input logic v, input int c);
        int bad;
        bad = 0;
        repeat (c) begin
            step(1);
            if (out(k) !== v) bad++;
        end
        checks_done++;
        if (bad != 0) fail($sformatf("output %0d left %b for %0d cycles", k, v, bad));
    endtask : hold

    initial begin
        req = '0;
        req.load_current_detector = 1'b1;
        req.pos_seq_voltage_detector = 1'b1;
        trip_src = '0;
        reclose_sel = '0;
        trip_any = 1'b0;
        switch_onto_fault_select = 1'b0;
        bypass_trip_delay = 1'b1;
        remote_open_select = 1'b0;
        overload_select = 1'b0;
        level1_pickup = 1'b0;
        level2_pickup = 1'b0;
        remote_open_delay_setting = 16'h0005;
        level1_delay_setting = 16'h0008;
        level2_delay_setting = 16'h0002;
        repeat (8) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        step(1);
        for (int k = 0; k < 8; k++) chk_bit(k, 1'b0);
        // Own selection blocks; every other selection must leave the trip reclosable
        for (int i = 0; i < 10; i++) begin
            trip_src = trip_src_s'(5'h10 >> (i % 5));
            reclose_sel = reclose_sel_s'((i < 5) ? (5'h10 >> i) : ~(5'h10 >> (i - 5)));
            trip_any = 1'b1;
            step(2);
            chk_bit(1, i < 5);
            chk_bit(0, i >= 5);
        end
        trip_any = 1'b0;
        reclose_sel = '0;
        step(2);
        chk_bit(0, 1'b0);
        switch_onto_fault_select = 1'b1;
        req.load_current_detector = 1'b0;
        req.pos_seq_voltage_detector = 1'b0;
        chk_ms(2, 1'b1, 150);
        req.pos_seq_overcurrent_unit = 1'b1;
        chk_win(3, 1'b1, 1, 3);
        req.pos_seq_overcurrent_unit = 1'b0;
        chk_win(3, 1'b0, 0, 3);
        bypass_trip_delay = 1'b0;
        req.zone2_ground = 1'b1;
        chk_ms(3, 1'b1, 45);
        req.zone2_ground = 1'b0;
        chk_win(3, 1'b0, 0, 3);
        req.zone2_phase = 1'b1;
        hold(3, 1'b0, 300);
        req.zone2_phase = 1'b0;
        step(2);
        req.zone2_phase = 1'b1;
        chk_ms(3, 1'b1, 45);
        req.zone2_phase = 1'b0;
        step(3);
        req.pos_seq_voltage_detector = 1'b1;
        chk_ms(2, 1'b0, 25);
        req.pos_seq_overcurrent_unit = 1'b1;
        hold(3, 1'b0, 20);
        switch_onto_fault_select = 1'b0;
        bypass_trip_delay = 1'b1;
        req.pos_seq_voltage_detector = 1'b0;
        hold(2, 1'b0, 1600);
        chk_bit(3, 1'b0);
        req.pos_seq_overcurrent_unit = 1'b0;
        req.pos_seq_voltage_detector = 1'b1;
        req.load_current_detector = 1'b1;
        remote_open_select = 1'b1;
        req.fault_detector = 1'b1;
        step(3);
        req.charging = 3'b010;
        chk_ms(4, 1'b1, 5);
        chk_bit(5, 1'b0);
        req.fault_detector = 1'b0;
        req.charging = 3'b000;
        chk_win(4, 1'b0, 0, 4);
        // Fault clearing before the delay runs out must not trip
        req.fault_detector = 1'b1;
        step(3);
        req.charging = 3'b100;
        step(20);
        req.fault_detector = 1'b0;
        hold(4, 1'b0, 100);
        // Charging left behind after the fault clears seals the latch in
        chk_bit(5, 1'b1);
        req.charging = 3'b000;
        chk_win(5, 1'b0, 1, 4);
        req.charging = 3'b001;
        chk_win(5, 1'b1, 1, 4);
        req.fault_detector = 1'b1;
        hold(4, 1'b0, 100);
        req.charging = 3'b101;
        step(2);
        req.charging = 3'b100;
        step(3);
        chk_bit(5, 1'b1);
        req.charging = 3'b000;
        chk_win(5, 1'b0, 1, 4);
        hold(4, 1'b0, 100);
        req.fault_detector = 1'b0;
        step(3);
        remote_open_select = 1'b0;
        req.fault_detector = 1'b1;
        step(3);
        req.charging = 3'b111;
        hold(4, 1'b0, 100);
        req.charging = 3'b000;
        req.fault_detector = 1'b0;
        overload_select = 1'b1;
        level2_pickup = 1'b1;
        chk_ms(7, 1'b1, 2);
        chk_bit(6, 1'b0);
        level2_pickup = 1'b0;
        level1_pickup = 1'b1;
        chk_ms(6, 1'b1, 8);
        chk_bit(7, 1'b0);
        overload_select = 1'b0;
        level2_pickup = 1'b1;
        step(3);
        hold(6, 1'b0, 150);
        chk_bit(7, 1'b0);
        summarize();
    end
endmodule : tb_line_pickup_remote_open_logic
